//--- rtl/bcr_pkg.sv
// Operation
// - direct jump loads low pc from address field
// - jump opcode codes 0c-0f select pages 0-3
// - jump field is an offset from page base
// - register jump copies jump target, stack untouched
// - direct call pushes pc+1, loads field, page 0
// - direct call reaches page 0 entries only
// - register call pushes pc+1, loads jump target
// - system call sets segment, builds pc from entry fields
// - system call entry operand is seven bits
// - plain return pops pc, stack pointer plus one
// - skip return pops pc then adds one
// - interrupt return pops pc, restores saved state
// - vectored interrupt saves the program status word
// - interrupt return restores state even outside interrupts
package bcr_pkg;
  // default sizes
  localparam int PC_W_DEF    = 16;
  localparam int AR_W_DEF    = 16;
  localparam int STK_DEPTH   = 8;
  localparam int SP_W_DEF    = 3;
  localparam int PAGE_W_DEF  = 2;
  localparam int SEG_W       = 4;
  localparam int PSW_W       = 4;
  localparam int BANK_W      = 4;
  localparam int INST_W      = 16;
  localparam int ADR_W       = 8;
  localparam int DAT_W       = 32;
  localparam int SEL_W       = 4;

  // instruction fields
  localparam int ADDR_W      = 11;
  localparam int PAGE_LSB    = 11;
  localparam int OPC_LSB     = 11;
  localparam int OPC_W       = 5;
  localparam int JMP_LSB     = 13;
  localparam int ENTH_LSB    = 8;
  localparam int ENTH_W      = 3;
  localparam int SUB_LSB     = 4;
  localparam int SUB_W       = 4;
  localparam int ENTL_W      = 4;
  localparam logic [2:0]       OPC_JMP_HI  = 3'h3;
  localparam logic [OPC_W-1:0] OPC_GRP     = 5'h07;
  localparam logic [OPC_W-1:0] OPC_CALL    = 5'h1d;
  localparam logic [SUB_W-1:0] SUB_SYSTEM_ENTRY_OP  = 4'h0;
  localparam logic [SUB_W-1:0] SUB_BR_AR   = 4'h4;
  localparam logic [SUB_W-1:0] SUB_CALL_AR = 4'h5;
  localparam logic [SUB_W-1:0] SUB_RETURN_SKIP_OP   = 4'h6;
  localparam logic [SUB_W-1:0] SUB_INTERRUPT_RETURN_OP    = 4'h7;
  localparam logic [SUB_W-1:0] SUB_RET     = 4'he;

  // register offsets and field positions
  localparam logic [ADR_W-1:0] REG_JUMP = 8'h00;
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h04;
  localparam logic [ADR_W-1:0] REG_STAT = 8'h08;
  localparam logic [ADR_W-1:0] REG_SAVE = 8'h0c;
  localparam int CTRL_PSW_LSB  = 0;
  localparam int CTRL_BANK_LSB = 4;
  localparam int STAT_PC_LSB   = 0;
  localparam int STAT_SEG_LSB  = 16;
  localparam int STAT_SP_LSB   = 24;

  // reset values and the system call segment
  localparam logic [SEG_W-1:0]  SEG_RST  = 4'h0;
  localparam logic [SEG_W-1:0]  SYS_SEG  = 4'h1;
  localparam logic [PSW_W-1:0]  PSW_RST  = 4'h0;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;

  typedef enum logic [8:0] {
    BCR_OP_OTHER   = 9'h001,
    BCR_OP_JUMP    = 9'h002,
    BCR_OP_JUMP_AR = 9'h004,
    BCR_OP_CALL    = 9'h008,
    BCR_OP_CALL_AR = 9'h010,
    BCR_OP_SYSTEM  = 9'h020,
    BCR_OP_RET     = 9'h040,
    BCR_OP_RETURN_SKIP_OP   = 9'h080,
    BCR_OP_INTERRUPT_RETURN_OP    = 9'h100
  } bcr_op_t;
endpackage

//--- rtl/bcr_decode.sv
`timescale 1ns/100ps
module bcr_decode (
  input  wire logic [bcr_pkg::INST_W-1:0] inst_word,
  output bcr_pkg::bcr_op_t                op
);
  import bcr_pkg::*;

  function automatic bcr_op_t decode(input logic [INST_W-1:0] w);
    logic [OPC_W-1:0] opc;
    logic [SUB_W-1:0] sub;
    opc = w[OPC_LSB +: OPC_W];
    sub = w[SUB_LSB +: SUB_W];
    decode = BCR_OP_OTHER;
    if (w[INST_W-1:JMP_LSB] == OPC_JMP_HI) begin
      decode = BCR_OP_JUMP;
    end else if (opc == OPC_CALL) begin
      decode = BCR_OP_CALL;
    end else if (opc == OPC_GRP) begin
      // the system call uses the high entry bits, so only it ignores bits 10-8
      if (sub == SUB_SYSTEM_ENTRY_OP) begin
        decode = BCR_OP_SYSTEM;
      end else if (w[ENTH_LSB +: ENTH_W] == 3'h0) begin
        case (sub)
          SUB_BR_AR:   decode = BCR_OP_JUMP_AR;
          SUB_CALL_AR: decode = BCR_OP_CALL_AR;
          SUB_RET:     decode = BCR_OP_RET;
          SUB_RETURN_SKIP_OP:   decode = BCR_OP_RETURN_SKIP_OP;
          SUB_INTERRUPT_RETURN_OP:    decode = BCR_OP_INTERRUPT_RETURN_OP;
          default:     decode = BCR_OP_OTHER;
        endcase
      end
    end
  endfunction

  // pure decode, no state
  assign op = decode(inst_word);
endmodule

//--- rtl/bcr_addr_stack.sv
`timescale 1ns/100ps
module bcr_addr_stack #(
  parameter int DEPTH = bcr_pkg::STK_DEPTH,
  parameter int SP_W  = bcr_pkg::SP_W_DEF,
  parameter int W     = bcr_pkg::PC_W_DEF
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [W-1:0]    wdata,
  output logic      [SP_W-1:0] sp,
  output logic      [W-1:0]    top
);
  import bcr_pkg::*;

  typedef struct packed {
    logic [SP_W-1:0]           sp;
    logic [DEPTH-1:0][W-1:0]   mem;
  } bcr_stk_t;

  bcr_stk_t s_r;
  bcr_stk_t s_nxt;

  // push predecrements, pop reads first then postincrements
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.sp = s_r.sp - SP_W'(1);
      s_nxt.mem[s_nxt.sp] = wdata;
    end else if (pop) begin
      s_nxt.sp = s_r.sp + SP_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sp  = s_r.sp;
  assign top = s_r.mem[s_r.sp]; // no bounds flag: overflow wraps silently
endmodule

//--- rtl/bcr_flow_ctrl.sv
`timescale 1ns/100ps
module bcr_flow_ctrl #(
  parameter int PC_W      = bcr_pkg::PC_W_DEF,
  parameter int AR_W      = bcr_pkg::AR_W_DEF,
  parameter int STK_DEPTH = bcr_pkg::STK_DEPTH,
  parameter int SP_W      = bcr_pkg::SP_W_DEF,
  parameter int PAGE_W    = bcr_pkg::PAGE_W_DEF
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic [bcr_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [bcr_pkg::DAT_W-1:0]   wb_dat_i,
  input  wire logic [bcr_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic                        wb_we_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  output logic      [bcr_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [bcr_pkg::INST_W-1:0]  inst_word,
  input  wire logic                        inst_valid,
  input  wire logic                        int_take,
  input  wire logic [PC_W-1:0]             int_vector,
  output logic      [PC_W-1:0]             fetch_addr,
  output logic      [PAGE_W-1:0]           page_sel,
  output logic      [bcr_pkg::SEG_W-1:0]   segment_select,
  output logic      [bcr_pkg::PSW_W-1:0]   program_status_word,
  output logic      [bcr_pkg::BANK_W-1:0]  bank_sel
);
  import bcr_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0]         pc;
    logic [AR_W-1:0]         jt;
    logic [SEG_W-1:0]        seg;
    logic [PSW_W-1:0]        psw;
    logic [BANK_W-1:0]       bank;
    logic [BANK_W+PSW_W-1:0] save;
    logic                    ack;
    logic [DAT_W-1:0]        dat;
  } bcr_state_t;

  bcr_state_t        s_r;
  bcr_state_t        s_nxt;
  bcr_op_t           op;
  logic [SP_W-1:0]   sp;
  logic [PC_W-1:0]   top;
  logic [PC_W-1:0]   pc_inc;
  logic [PC_W-1:0]   push_val;
  logic [DAT_W-1:0]  stat_word;
  logic [DAT_W-1:0]  ctrl_word;
  logic [DAT_W-1:0]  jt_word;
  logic [DAT_W-1:0]  ctrl_wr;
  logic [DAT_W-1:0]  jt_wr;
  logic              exec;
  logic              push;
  logic              pop;
  logic              wb_req;

  // byte-lane merge shared by every writable register
  function automatic logic [DAT_W-1:0] lane_merge(input logic [DAT_W-1:0] old_v,
                                                  input logic [DAT_W-1:0] new_v,
                                                  input logic [SEL_W-1:0] sel);
    lane_merge = old_v;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  bcr_decode u_decode (
    .inst_word (inst_word),
    .op        (op)
  );

  bcr_addr_stack #(
    .DEPTH (STK_DEPTH),
    .SP_W  (SP_W),
    .W     (PC_W)
  ) u_stack (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .push    (push),
    .pop     (pop),
    .wdata   (push_val),
    .sp      (sp),
    .top     (top)
  );

  // an accepted interrupt replaces the instruction in that cycle
  assign exec     = inst_valid & ~int_take;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign pc_inc   = s_r.pc + PC_W'(1);
  assign push     = int_take | (exec & (op == BCR_OP_CALL || op == BCR_OP_CALL_AR || op == BCR_OP_SYSTEM));
  assign pop      = exec & (op == BCR_OP_RET || op == BCR_OP_RETURN_SKIP_OP || op == BCR_OP_INTERRUPT_RETURN_OP);
  // interrupt resumes the pre-empted instruction, calls resume after themselves
  assign push_val = int_take ? s_r.pc : pc_inc;

  // read views of the registers
  always_comb begin
    stat_word = '0;
    stat_word[STAT_PC_LSB +: PC_W]  = s_r.pc;
    stat_word[STAT_SEG_LSB +: SEG_W] = s_r.seg;
    stat_word[STAT_SP_LSB +: SP_W]   = sp;
    ctrl_word = '0;
    ctrl_word[CTRL_PSW_LSB +: PSW_W]   = s_r.psw;
    ctrl_word[CTRL_BANK_LSB +: BANK_W] = s_r.bank;
    jt_word = '0;
    jt_word[AR_W-1:0] = s_r.jt;
  end

  // merged write images are named so that their fields can be selected
  assign ctrl_wr = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
  assign jt_wr   = lane_merge(jt_word, wb_dat_i, wb_sel_i);

  // next state: bus first, then instruction flow so hardware updates win
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = wb_req;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        REG_JUMP: s_nxt.dat = jt_word;
        REG_CTRL: s_nxt.dat = ctrl_word;
        REG_STAT: s_nxt.dat = stat_word;
        REG_SAVE: s_nxt.dat = DAT_W'(s_r.save);
        default:  s_nxt.dat = '0;
      endcase
    end
    if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        REG_JUMP: s_nxt.jt = jt_wr[AR_W-1:0];
        REG_CTRL: begin
          s_nxt.psw  = ctrl_wr[CTRL_PSW_LSB +: PSW_W];
          s_nxt.bank = ctrl_wr[CTRL_BANK_LSB +: BANK_W];
        end
        default: s_nxt.jt = s_r.jt;
      endcase
    end
    if (int_take) begin
      s_nxt.save = {s_r.bank, s_r.psw};
      s_nxt.pc   = int_vector;
    end else if (inst_valid) begin
      // each flow instruction settles the next fetch address in this cycle
      case (op)
        BCR_OP_JUMP: begin
          s_nxt.pc = '0;
          s_nxt.pc[PAGE_LSB +: PAGE_W] = inst_word[PAGE_LSB +: PAGE_W];
          s_nxt.pc[ADDR_W-1:0] = inst_word[ADDR_W-1:0];
        end
        BCR_OP_JUMP_AR: s_nxt.pc = PC_W'(s_r.jt);
        BCR_OP_CALL: begin
          s_nxt.pc = '0;
          s_nxt.pc[ADDR_W-1:0] = inst_word[ADDR_W-1:0];
        end
        BCR_OP_CALL_AR: s_nxt.pc = PC_W'(s_r.jt);
        BCR_OP_SYSTEM: begin
          // only 3+4 entry bits exist, so targets span 0x000-0x70f
          s_nxt.seg = SYS_SEG;
          s_nxt.pc  = '0;
          s_nxt.pc[ENTH_LSB +: ENTH_W] = inst_word[ENTH_LSB +: ENTH_W];
          s_nxt.pc[ENTL_W-1:0] = inst_word[ENTL_W-1:0];
        end
        BCR_OP_RET:   s_nxt.pc = top;
        BCR_OP_RETURN_SKIP_OP: s_nxt.pc = top + PC_W'(1);
        BCR_OP_INTERRUPT_RETURN_OP: begin
          // restore is unconditional, so misuse after a plain call clobbers bank
          s_nxt.pc = top;
          {s_nxt.bank, s_nxt.psw} = s_r.save;
        end
        default: s_nxt.pc = pc_inc;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_r      <= '0;
      s_r.seg  <= SEG_RST;
      s_r.psw  <= PSW_RST;
      s_r.bank <= BANK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fetch_addr          = s_r.pc;
  assign page_sel            = s_r.pc[PAGE_LSB +: PAGE_W];
  assign segment_select      = s_r.seg;
  assign program_status_word = s_r.psw;
  assign bank_sel            = s_r.bank;
  assign wb_dat_o            = s_r.dat;
  assign wb_ack_o            = s_r.ack;

  // checks
  logic do_op;
  assign do_op = exec;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  jump_page_a: assert property (do_op && op == BCR_OP_JUMP |=>
      page_sel == $past(inst_word[PAGE_LSB +: PAGE_W])) else $error("jump page wrong");
  jump_field_a: assert property (do_op && op == BCR_OP_JUMP |=>
      fetch_addr[ADDR_W-1:0] == $past(inst_word[ADDR_W-1:0])) else $error("jump offset wrong");
  jump_reg_a: assert property (do_op && op == BCR_OP_JUMP_AR |=>
      fetch_addr == PC_W'($past(s_r.jt)) && $stable(sp)) else $error("register jump wrong");
  call_push_a: assert property (do_op && op == BCR_OP_CALL |=>
      sp == SP_W'($past(sp) - SP_W'(1)) && top == $past(pc_inc) && page_sel == '0)
      else $error("direct call wrong");
  call_reg_a: assert property (do_op && op == BCR_OP_CALL_AR |=>
      fetch_addr == PC_W'($past(s_r.jt)) && top == $past(pc_inc)) else $error("register call wrong");
  sys_call_a: assert property (do_op && op == BCR_OP_SYSTEM |=>
      segment_select == SYS_SEG && fetch_addr[SUB_LSB +: SUB_W] == '0 && top == $past(pc_inc))
      else $error("system call wrong");
  plain_ret_a: assert property (do_op && op == BCR_OP_RET |=>
      fetch_addr == $past(top) && sp == SP_W'($past(sp) + SP_W'(1))) else $error("return wrong");
  skip_ret_a: assert property (do_op && op == BCR_OP_RETURN_SKIP_OP |=>
      fetch_addr == PC_W'($past(top) + PC_W'(1))) else $error("skip return wrong");
  int_ret_a: assert property (do_op && op == BCR_OP_INTERRUPT_RETURN_OP |=>
      {bank_sel, program_status_word} == $past(s_r.save) && fetch_addr == $past(top))
      else $error("interrupt return wrong");
  int_save_a: assert property (int_take |=> s_r.save == $past({bank_sel, program_status_word})
      && top == $past(fetch_addr) && fetch_addr == $past(int_vector)) else $error("interrupt save wrong");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack timing wrong");

  // helper views of a newly taken bus request
  logic bus_wr;
  logic bus_rd;
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // ack only ever answers a request of the cycle before
  ack_req_a: assert property (wb_ack_o |->
      $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
  // first edge after reset sees pc, stack pointer, segment, ack, status and bank at their reset values
  reset_state_a: assert property ($rose(rst_b) |->
      fetch_addr == '0 && sp == '0 && segment_select == SEG_RST && !wb_ack_o
      && program_status_word == PSW_RST && bank_sel == BANK_RST) else $error("reset state wrong");
  // a direct jump leaves the stack and the segment alone
  jump_stack_a: assert property (do_op && op == BCR_OP_JUMP |=>
      $stable(sp) && $stable(segment_select))
      else $error("direct jump moved the stack");
  // the page code picks a base and the field counts on from it, nothing above
  jump_base_a: assert property (do_op && op == BCR_OP_JUMP |=>
      fetch_addr == PC_W'({$past(inst_word[PAGE_LSB +: PAGE_W]), $past(inst_word[ADDR_W-1:0])}))
      else $error("jump target outside page");
  // a direct call can only land on page 0
  call_page_a: assert property (do_op && op == BCR_OP_CALL |=>
      fetch_addr[PC_W-1:ADDR_W] == '0)
      else $error("direct call left page 0");
  // the register call takes one stack level like the direct one
  reg_call_sp_a: assert property (do_op && op == BCR_OP_CALL_AR |=>
      sp == SP_W'($past(sp) - SP_W'(1)))
      else $error("register call stack level wrong");
  // system call target comes only from the two entry fields, on page 0
  sys_page_a: assert property (do_op && op == BCR_OP_SYSTEM |=>
      page_sel == '0 && fetch_addr[ENTH_LSB +: ENTH_W] == $past(inst_word[ENTH_LSB +: ENTH_W])
      && fetch_addr[ENTL_W-1:0] == $past(inst_word[ENTL_W-1:0]) && sp == SP_W'($past(sp) - SP_W'(1)))
      else $error("system call target wrong");
  // segment moves only on a system call
  seg_hold_a: assert property (!(do_op && op == BCR_OP_SYSTEM) |=>
      $stable(segment_select))
      else $error("segment changed without system call");
  // a plain return also restores the page of the return address
  ret_page_a: assert property (do_op && op == BCR_OP_RET |=>
      page_sel == $past(top[PAGE_LSB +: PAGE_W]))
      else $error("return page wrong");
  // both special returns release one stack level
  skip_sp_a: assert property (do_op && op == BCR_OP_RETURN_SKIP_OP |=>
      sp == SP_W'($past(sp) + SP_W'(1)))
      else $error("skip return stack level wrong");
  interrupt_return_op_sp_a: assert property (do_op && op == BCR_OP_INTERRUPT_RETURN_OP |=>
      sp == SP_W'($past(sp) + SP_W'(1)))
      else $error("interrupt return stack level wrong");
  // an accepted interrupt takes one stack level
  int_push_a: assert property (int_take |=>
      sp == SP_W'($past(sp) - SP_W'(1)))
      else $error("interrupt stack level wrong");
  // save register reads back what the interrupt captured
  save_read_a: assert property (bus_rd && wb_adr_i == REG_SAVE |=>
      wb_dat_o == DAT_W'($past(s_r.save)))
      else $error("save read wrong");
  // a full-width target write lands whole
  jt_write_a: assert property (bus_wr && wb_adr_i == REG_JUMP && &wb_sel_i |=>
      s_r.jt == $past(wb_dat_i[AR_W-1:0]))
      else $error("jump target write wrong");
  // bus writes to control land unless an interrupt return overrides them
  ctrl_write_a: assert property (bus_wr && wb_adr_i == REG_CTRL && &wb_sel_i
      && !(do_op && op == BCR_OP_INTERRUPT_RETURN_OP) |=> program_status_word == $past(wb_dat_i[CTRL_PSW_LSB +: PSW_W])
      && bank_sel == $past(wb_dat_i[CTRL_BANK_LSB +: BANK_W])) else $error("control write wrong");
  // neither the count nor the stack moves without an executed instruction or an accepted interrupt
  idle_hold_a: assert property (!inst_valid && !int_take |=>
      $stable(fetch_addr) && $stable(sp))
      else $error("state moved while idle");
  // any other opcode just advances to the next word
  step_other_a: assert property (do_op && op == BCR_OP_OTHER |=>
      fetch_addr == PC_W'($past(fetch_addr) + PC_W'(1)) && $stable(sp))
      else $error("plain step wrong");

  call_ret_c: cover property (do_op && op == BCR_OP_CALL ##[1:60] do_op && op == BCR_OP_RET);
  int_interrupt_return_op_c: cover property (int_take ##[1:20] do_op && op == BCR_OP_INTERRUPT_RETURN_OP);
  sys_call_c: cover property (do_op && op == BCR_OP_SYSTEM);
  bus_write_c: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);
  skip_ret_c: cover property (do_op && op == BCR_OP_RETURN_SKIP_OP);
endmodule

//--- tb/bcr_prog_mem.sv
`timescale 1ns/100ps
module bcr_prog_mem
  import bcr_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic                        sys_clk,
  input  wire logic                        ld_en,
  input  wire logic [PC_W-1:0]             ld_addr,
  input  wire logic [bcr_pkg::INST_W-1:0]  ld_data,
  input  wire logic [PC_W-1:0]             fetch_addr,
  output logic      [bcr_pkg::INST_W-1:0]  inst_word
);
  logic [INST_W-1:0] mem_r [2**PC_W];

  // unloaded words read as zero, a non-flow opcode, so stray fetches only advance
  initial begin
    foreach (mem_r[i]) mem_r[i] = '0;
  end

  // load port stands in for programming the memory
  always @(posedge sys_clk) begin
    if (ld_en) begin
      mem_r[ld_addr] <= ld_data;
    end
  end

  // combinational read: word at the program counter settles well before the next edge
  assign inst_word = mem_r[fetch_addr];
endmodule

//--- tb/branch_call_return_control_test.sv
`timescale 1ns/100ps
module branch_call_return_control_test;
  import bcr_pkg::*;
  localparam int PCW = 16;
  // program image: address / word pairs
  localparam logic [15:0] PROG_A [12] = '{16'h0000, 16'h1010, 16'h0020, 16'h0805, 16'h0010, 16'h0807,
                                          16'h1fff, 16'h2345, 16'h050a, 16'h2346, 16'h2000, 16'h0100};
  localparam logic [15:0] PROG_D [12] = '{16'h7010, 16'h6020, 16'h6805, 16'he810, 16'h3860, 16'h7fff,
                                          16'h3850, 16'h3d0a, 16'h38e0, 16'h38e0, 16'h3840, 16'h3870};
  // expected program counter and stack pointer after each executed step
  localparam logic [15:0] EXP_PC [10] = '{16'h1010, 16'h0020, 16'h0805, 16'h0010, 16'h0807,
                                          16'h1fff, 16'h2345, 16'h050a, 16'h2346, 16'h2000};
  localparam logic [2:0]  EXP_SP [10] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 3'h7, 3'h6, 3'h7, 3'h0};

  logic              sys_clk;
  logic              rst_b;
  logic [ADR_W-1:0]  wb_adr_i;
  logic [DAT_W-1:0]  wb_dat_i;
  logic [SEL_W-1:0]  wb_sel_i;
  logic              wb_we_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic [DAT_W-1:0]  wb_dat_o;
  logic              wb_ack_o;
  logic [INST_W-1:0] inst_word;
  logic              inst_valid;
  logic              int_take;
  logic [PCW-1:0]    int_vector;
  logic [PCW-1:0]    fetch_addr;
  logic [1:0]        page_sel;
  logic [SEG_W-1:0]  segment_select;
  logic [PSW_W-1:0]  program_status_word;
  logic [BANK_W-1:0] bank_sel;
  logic              ld_en;
  logic [PCW-1:0]    ld_addr;
  logic [INST_W-1:0] ld_data;
  logic [DAT_W-1:0]  d;
  int                failures;
  int                checks_done;
  int                cycles;

  bcr_flow_ctrl #(.PC_W(PCW), .AR_W(16), .STK_DEPTH(8), .SP_W(3), .PAGE_W(2)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .inst_word(inst_word), .inst_valid(inst_valid), .int_take(int_take), .int_vector(int_vector),
    .fetch_addr(fetch_addr), .page_sel(page_sel), .segment_select(segment_select),
    .program_status_word(program_status_word), .bank_sel(bank_sel));

  bcr_prog_mem #(.PC_W(PCW)) pmem (
    .sys_clk(sys_clk), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .fetch_addr(fetch_addr), .inst_word(inst_word));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs under two hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // classic single cycle; the request holds until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] wd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    check(d, exp);
  endtask

  task automatic sp_chk(input logic [2:0] exp);
    wb_xfer(1'b0, REG_STAT, 32'h0);
    check({29'h0, d[STAT_SP_LSB+:3]}, {29'h0, exp});
  endtask

  // one executed instruction or accepted interrupt, results looked at mid-cycle
  task automatic step(input logic irq, input logic [PCW-1:0] vec);
    @(posedge sys_clk);
    inst_valid <= ~irq;
    int_take   <= irq;
    int_vector <= vec;
    @(posedge sys_clk);
    inst_valid <= 1'b0;
    int_take   <= 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    rst_b = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'hf;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    inst_valid = 1'b0;
    int_take = 1'b0;
    int_vector = '0;
    ld_en = 1'b0;
    ld_addr = '0;
    ld_data = '0;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    // six cycles of reset; the image loads afterwards while nothing executes
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (PROG_A[i]) begin
      @(posedge sys_clk);
      ld_en   <= 1'b1;
      ld_addr <= PROG_A[i];
      ld_data <= PROG_D[i];
    end
    @(posedge sys_clk);
    ld_en <= 1'b0;
    rd_chk(REG_STAT, 32'h0);
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(8'h10, 32'h0);
    wb_xfer(1'b1, REG_JUMP, 32'h2345);
    // page jumps, calls, skip return, system call and returns in one walk
    for (int i = 0; i < 10; i++) begin
      step(1'b0, '0);
      check({16'h0, fetch_addr}, {16'h0, EXP_PC[i]});
      check({30'h0, page_sel}, {30'h0, EXP_PC[i][12:11]});
      sp_chk(EXP_SP[i]);
      if (i == 7) begin
        rd_chk(REG_STAT, {5'h0, 3'h6, 4'h0, SYS_SEG, 16'h050a});
        check({28'h0, segment_select}, {28'h0, SYS_SEG});
      end
    end
    // interrupt saves status, return restores it over a later bus write
    wb_xfer(1'b1, REG_CTRL, 32'ha3);
    step(1'b1, 16'h0100);
    check({16'h0, fetch_addr}, 32'h0100);
    sp_chk(3'h7);
    wb_xfer(1'b1, REG_CTRL, 32'h0);
    rd_chk(REG_SAVE, 32'ha3);
    step(1'b0, '0);
    check({16'h0, fetch_addr}, 32'h2000);
    sp_chk(3'h0);
    check({24'h0, bank_sel, program_status_word}, 32'ha3);
    // register jump leaves the stack alone, then a stray interrupt return
    wb_xfer(1'b1, REG_CTRL, 32'h55);
    wb_xfer(1'b1, REG_JUMP, 32'h0100);
    step(1'b0, '0);
    check({16'h0, fetch_addr}, 32'h0100);
    sp_chk(3'h0);
    step(1'b0, '0);
    check({16'h0, fetch_addr}, 32'h0);
    sp_chk(3'h1);
    rd_chk(REG_CTRL, 32'ha3);
    // interrupt into blank memory: a non-flow word only advances the count
    step(1'b1, 16'h0300);
    step(1'b0, '0);
    check({16'h0, fetch_addr}, 32'h0301);
    sp_chk(3'h0);
    print_verdict();
  end
endmodule
